// *** core/servo_match_clamp.sv ***
/*
  Servo position match output, two-set gain selection, control mode
  selection and zero speed clamp, with a classic Wishbone register slave.
  Assumes position, velocity and torque samples synchronous to i_mclk.
*/
`timescale 1ns/1ps
// Operation
// - The match output is active while actual position is within 100 pulses of the target.
// - The target is a signed 32-bit pulse count that resets to 10000.
// - Code 04 closes the output on match and code 31 keeps it open without match.
// - Code 32 inverts the output so it is open on match and closed otherwise.
// - Two gain sets are kept and chosen by a switching method that resets to 0.
// - Switching is judged on position error, velocity and torque thresholds, torque default 10.
// - Returning from second to first gains waits 10 ms by default; the reverse waits 0.
// - Mode 15 selects command velocity and mode 21 is used for direct Modbus motion.
// - The clamp holds the shaft by engaging the position loop inside velocity mode.
// - With clamp method 0 the clamp depends on the clamp request input.
// - With method 0 the lock starts when the input is valid and command speed is low.
// - While locked the lock position is kept and the loop drives back to it.
// - With input code 01 a low input plus a low command speed makes the clamp valid.
// - The zero speed threshold runs 0.1 to 2 rps, default 0.5, and equal counts as zero.
module servo_match_clamp
  import servo_pkg::*;
#(
  parameter int unsigned MS_TICKS = MS_CYCLES
) (
  // Clock and reset.
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Wishbone slave.
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  // Motion feedback, velocities in 0.01 rps, torque in 0.1 %.
  input  wire logic [31:0] i_actual_pos,
  input  wire logic [31:0] i_pos_error,
  input  wire logic [15:0] i_cmd_velocity,
  input  wire logic [15:0] i_actual_velocity,
  input  wire logic [15:0] i_actual_torque,
  input  wire logic        i_clamp_request_input,
  // Outputs to the drive.
  output logic             o_position_match_output,
  output logic             o_gain_set2,
  output logic             o_velocity_mode,
  output logic             o_position_lock,
  output logic [31:0]      o_lock_position,
  output logic             o_irq
);

  typedef struct packed {
    logic [31:0] target;
    logic [7:0]  out_code;
    logic [7:0]  mode;
    logic [2:0]  clamp_meth;
    logic [15:0] zero_thr;
    logic [7:0]  gs_method;
    logic [31:0] gs_poserr;
    logic [15:0] gs_vel;
    logic [15:0] gs_torq;
    logic [15:0] dly_2to1;
    logic [15:0] dly_1to2;
    logic [7:0]  in_code;
    logic [NUM_EVT-1:0] irq_stat;
    logic [NUM_EVT-1:0] irq_mask;
    logic        match_out;
    logic        match_q;
    logic        gain2;
    logic        lock;
    logic [31:0] lock_pos;
    logic [31:0] rdata;
    logic        ack;
    logic        irq;
    logic        vel_mode;
  } core_state_t;

  core_state_t st;
  core_state_t next_st;

  logic        in_window;
  logic        clamp_valid;
  logic        want_gain2;
  logic        to2_done;
  logic        to1_done;
  logic [31:0] diff;
  logic [31:0] abs_diff;
  logic [15:0] abs_cmd_vel;
  logic [31:0] abs_poserr;
  logic [15:0] abs_act_vel;
  logic [15:0] abs_torq;
  logic        wb_req;
  logic [31:0] wmask;

  //////////////////////////////////////////////////////////////////////////////
  // Condition evaluation.

  // Signed distance to the target, judged every clock.
  always_comb begin
    diff        = i_actual_pos - st.target;
    abs_diff    = diff[31] ? (32'h0 - diff) : diff;
    abs_cmd_vel = i_cmd_velocity[15] ? (16'h0 - i_cmd_velocity) : i_cmd_velocity;
    abs_poserr  = i_pos_error[31] ? (32'h0 - i_pos_error) : i_pos_error;
    abs_act_vel = i_actual_velocity[15] ? (16'h0 - i_actual_velocity) : i_actual_velocity;
    abs_torq    = i_actual_torque[15] ? (16'h0 - i_actual_torque) : i_actual_torque;
    in_window   = (abs_diff <= MATCH_TOL);
  end

  // Clamp request qualification; code 01 means the input is low-active.
  always_comb begin
    logic input_valid;
    input_valid = (st.in_code == IN_LOW_ACTIVE) ? !i_clamp_request_input
                                                : i_clamp_request_input;
    clamp_valid = (st.clamp_meth == RST_CLAMP_METH)
               && (st.mode == MODE_CMD_VEL)
               && input_valid
               && (abs_cmd_vel <= st.zero_thr);
  end

  // Gain switching demand from the selected method.
  always_comb begin
    unique case (st.gs_method)
      GS_POS_ERR:  want_gain2 = abs_poserr > st.gs_poserr;
      GS_VELOCITY: want_gain2 = abs_act_vel > st.gs_vel;
      GS_TORQUE:   want_gain2 = abs_torq > st.gs_torq;
      default:     want_gain2 = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Gain change delays.

  // First to second set waits for the demand to hold its delay.
  servo_ms_delay #(.MS_TICKS(MS_TICKS)) u_dly_1to2 (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_req      (want_gain2 && !st.gain2),
    .i_delay_ms (st.dly_1to2),
    .o_done     (to2_done)
  );

  // Second to first set waits for the demand to be absent its delay.
  servo_ms_delay #(.MS_TICKS(MS_TICKS)) u_dly_2to1 (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_req      (!want_gain2 && st.gain2),
    .i_delay_ms (st.dly_2to1),
    .o_done     (to1_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next state.

  assign wb_req = i_wb_cyc && i_wb_stb && !st.ack;
  assign wmask  = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

  always_comb begin
    logic [NUM_EVT-1:0] evt;
    logic [31:0]        wv;
    logic [31:0]        thr;
    next_st = st;
    evt     = '0;
    wv      = '0;
    thr     = '0;

    // Output polarity; unknown codes leave the output open.
    next_st.match_q = in_window;
    unique case (st.out_code)
      OUT_CLOSE_ON, OUT_OPEN_OFF: next_st.match_out = in_window;
      OUT_INVERT:                 next_st.match_out = !in_window;
      default:                    next_st.match_out = 1'b0;
    endcase

    // Gain set selection; the demand must still stand when the delay runs out,
    // so a method change in the same cycle cannot leave a stale switch behind.
    if (!st.gain2 && to2_done && want_gain2) begin
      next_st.gain2 = 1'b1;
    end else if (st.gain2 && to1_done && !want_gain2) begin
      next_st.gain2 = 1'b0;
    end

    // Position lock: catch the position on entry and hold it.
    if (clamp_valid && !st.lock) begin
      next_st.lock     = 1'b1;
      next_st.lock_pos = i_actual_pos;
    end else if (!clamp_valid) begin
      next_st.lock = 1'b0;
    end

    // Events on rising edges of match, lock and gain set 2.
    evt[BIT_MATCH] = in_window && !st.match_q;
    evt[BIT_LOCK]  = next_st.lock && !st.lock;
    evt[BIT_GAIN2] = next_st.gain2 && !st.gain2;

    // Bus access, answered one cycle after the request.
    next_st.ack = wb_req;
    if (wb_req && !i_wb_we) begin
      unique case (i_wb_adr)
        OFS_TARGET:        next_st.rdata = st.target;
        OFS_OUT_CODE:      next_st.rdata = {24'h0, st.out_code};
        OFS_MODE:          next_st.rdata = {24'h0, st.mode};
        OFS_CLAMP_METH:    next_st.rdata = {29'h0, st.clamp_meth};
        OFS_ZERO_THR:      next_st.rdata = {16'h0, st.zero_thr};
        OFS_GS_METHOD:     next_st.rdata = {24'h0, st.gs_method};
        OFS_GS_POSERR:     next_st.rdata = st.gs_poserr;
        OFS_GS_VEL:        next_st.rdata = {16'h0, st.gs_vel};
        OFS_GS_TORQ:       next_st.rdata = {16'h0, st.gs_torq};
        OFS_DLY_2TO1:      next_st.rdata = {16'h0, st.dly_2to1};
        OFS_DLY_1TO2:      next_st.rdata = {16'h0, st.dly_1to2};
        OFS_STATUS:        next_st.rdata = {29'h0, st.gain2, st.lock, st.match_q};
        OFS_IRQ_STAT:      next_st.rdata = {29'h0, st.irq_stat};
        OFS_IRQ_MASK:      next_st.rdata = {29'h0, st.irq_mask};
        OFS_LOCK_POS:      next_st.rdata = st.lock_pos;
        OFS_CLAMP_IN_CODE: next_st.rdata = {24'h0, st.in_code};
        default:           next_st.rdata = 32'h0;
      endcase
    end

    // Reading the interrupt status clears it; new events win over the clear.
    if (wb_req && !i_wb_we && i_wb_adr == OFS_IRQ_STAT) begin
      next_st.irq_stat = evt;
    end else begin
      next_st.irq_stat = st.irq_stat | evt;
    end

    // Register writes; only the target honours the byte enables.
    if (wb_req && i_wb_we) begin
      unique case (i_wb_adr)
        OFS_TARGET: begin
          wv = (st.target & ~wmask) | (i_wb_dat & wmask);
          // The most negative count is outside the range and is clipped.
          next_st.target = (wv == 32'h8000_0000) ? 32'h8000_0001 : wv;
        end
        OFS_OUT_CODE:      next_st.out_code   = i_wb_dat[7:0];
        OFS_MODE: begin
          if (i_wb_dat[7:0] == MODE_CMD_VEL || i_wb_dat[7:0] == MODE_MODBUS) begin
            next_st.mode = i_wb_dat[7:0];
          end
        end
        OFS_CLAMP_METH:    next_st.clamp_meth = i_wb_dat[2:0];
        OFS_ZERO_THR: begin
          thr = {16'h0, i_wb_dat[15:0]};
          if (thr[15:0] < ZERO_THR_MIN) begin
            next_st.zero_thr = ZERO_THR_MIN;
          end else if (thr[15:0] > ZERO_THR_MAX) begin
            next_st.zero_thr = ZERO_THR_MAX;
          end else begin
            next_st.zero_thr = thr[15:0];
          end
        end
        OFS_GS_METHOD:     next_st.gs_method  = i_wb_dat[7:0];
        OFS_GS_POSERR:     next_st.gs_poserr  = i_wb_dat;
        OFS_GS_VEL:        next_st.gs_vel     = i_wb_dat[15:0];
        OFS_GS_TORQ:       next_st.gs_torq    = i_wb_dat[15:0];
        OFS_DLY_2TO1:      next_st.dly_2to1   = i_wb_dat[15:0];
        OFS_DLY_1TO2:      next_st.dly_1to2   = i_wb_dat[15:0];
        OFS_IRQ_MASK:      next_st.irq_mask   = i_wb_dat[NUM_EVT-1:0];
        OFS_CLAMP_IN_CODE: next_st.in_code    = i_wb_dat[7:0];
        default:           next_st.target     = st.target;
      endcase
    end

    // Mode flag is registered so the output comes straight from a flip-flop.
    next_st.vel_mode = (next_st.mode == MODE_CMD_VEL);
    next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st            <= '0;
      st.target     <= RST_TARGET;
      st.out_code   <= RST_OUT_CODE;
      st.mode       <= RST_MODE;
      st.clamp_meth <= RST_CLAMP_METH;
      st.zero_thr   <= RST_ZERO_THR;
      st.gs_method  <= RST_GS_METHOD;
      st.gs_poserr  <= RST_GS_POSERR;
      st.gs_vel     <= RST_GS_VEL;
      st.gs_torq    <= RST_GS_TORQ;
      st.dly_2to1   <= RST_DLY_2TO1;
      st.dly_1to2   <= RST_DLY_1TO2;
      st.in_code    <= RST_CLAMP_IN_CODE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register.
  assign o_position_match_output = st.match_out;
  assign o_gain_set2             = st.gain2;
  assign o_velocity_mode         = st.vel_mode;
  assign o_position_lock         = st.lock;
  assign o_lock_position         = st.lock_pos;
  assign o_wb_dat                = st.rdata;
  assign o_wb_ack                = st.ack;
  assign o_irq                   = st.irq;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence match_seen_s;
    in_window && (st.out_code == OUT_CLOSE_ON);
  endsequence

  match_close_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    match_seen_s |=> o_position_match_output)
    else $error("match output not closed after match");

  match_open_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!in_window && st.out_code == OUT_OPEN_OFF) |=> !o_position_match_output)
    else $error("match output not open without match");

  match_invert_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (st.out_code == OUT_INVERT) |=> (o_position_match_output == !$past(in_window)))
    else $error("inverted match output wrong");

  target_range_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    st.target != 32'h8000_0000)
    else $error("target outside range");

  gain_method0_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (st.gs_method == GS_FIXED_FIRST && !st.gain2) |=> !o_gain_set2)
    else $error("gain set changed under fixed method");

  // First cycle in which the demand for the second set has gone away.
  sequence gain_return_s;
    st.gain2 && !want_gain2 && $past(want_gain2) && (st.dly_2to1 != 16'h0);
  endsequence

  gain_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    gain_return_s |=> o_gain_set2 [*2])
    else $error("return to first gains without delay");

  lock_entry_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    clamp_valid |=> o_position_lock)
    else $error("lock not entered");

  lock_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (st.lock && clamp_valid) |=> $stable(o_lock_position))
    else $error("lock position moved while locked");

  lock_exit_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (st.clamp_meth != RST_CLAMP_METH) |=> !o_position_lock)
    else $error("lock without method 0");

  zero_thr_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    st.zero_thr >= ZERO_THR_MIN && st.zero_thr <= ZERO_THR_MAX)
    else $error("zero speed threshold out of range");

endmodule : servo_match_clamp

// *** core/servo_pkg.sv ***
/*
  Shared constants for the servo position match and zero clamp block:
  register offsets, reset values, selector codes and timing counts.
  Assumes a 125 MHz system clock and a 32-bit classic Wishbone bus.
*/
package servo_pkg;

  // Clock rate and time base.
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;

  // Register byte offsets.
  localparam logic [7:0] OFS_TARGET       = 8'h00;
  localparam logic [7:0] OFS_OUT_CODE     = 8'h04;
  localparam logic [7:0] OFS_MODE         = 8'h08;
  localparam logic [7:0] OFS_CLAMP_METH   = 8'h0c;
  localparam logic [7:0] OFS_ZERO_THR     = 8'h10;
  localparam logic [7:0] OFS_GS_METHOD    = 8'h14;
  localparam logic [7:0] OFS_GS_POSERR    = 8'h18;
  localparam logic [7:0] OFS_GS_VEL       = 8'h1c;
  localparam logic [7:0] OFS_GS_TORQ      = 8'h20;
  localparam logic [7:0] OFS_DLY_2TO1     = 8'h24;
  localparam logic [7:0] OFS_DLY_1TO2     = 8'h28;
  localparam logic [7:0] OFS_STATUS       = 8'h2c;
  localparam logic [7:0] OFS_IRQ_STAT     = 8'h30;
  localparam logic [7:0] OFS_IRQ_MASK     = 8'h34;
  localparam logic [7:0] OFS_LOCK_POS     = 8'h38;
  localparam logic [7:0] OFS_CLAMP_IN_CODE = 8'h3c;

  // Reset values.
  localparam logic [31:0] RST_TARGET      = 32'h0000_2710;
  localparam logic [7:0]  RST_OUT_CODE    = 8'h04;
  localparam logic [7:0]  RST_MODE        = 8'h15;
  localparam logic [2:0]  RST_CLAMP_METH  = 3'h0;
  localparam logic [15:0] RST_ZERO_THR    = 16'h0032;
  localparam logic [7:0]  RST_GS_METHOD   = 8'h00;
  localparam logic [31:0] RST_GS_POSERR   = 32'h0000_0000;
  localparam logic [15:0] RST_GS_VEL      = 16'h0000;
  localparam logic [15:0] RST_GS_TORQ     = 16'h000a;
  localparam logic [15:0] RST_DLY_2TO1    = 16'h000a;
  localparam logic [15:0] RST_DLY_1TO2    = 16'h0000;
  localparam logic [7:0]  RST_CLAMP_IN_CODE = 8'h01;

  // Match tolerance in pulses and threshold limits in 0.01 rps.
  localparam logic [31:0] MATCH_TOL       = 32'h0000_0064;
  localparam logic [15:0] ZERO_THR_MIN    = 16'h000a;
  localparam logic [15:0] ZERO_THR_MAX    = 16'h00c8;

  // Selector codes (values are decimal codes held as hex).
  localparam logic [7:0] OUT_CLOSE_ON     = 8'h04;
  localparam logic [7:0] OUT_OPEN_OFF     = 8'h1f;
  localparam logic [7:0] OUT_INVERT       = 8'h20;
  localparam logic [7:0] MODE_CMD_VEL     = 8'h0f;
  localparam logic [7:0] MODE_MODBUS      = 8'h15;
  localparam logic [7:0] IN_LOW_ACTIVE    = 8'h01;

  // Gain switching methods.
  localparam logic [7:0] GS_FIXED_FIRST   = 8'h00;
  localparam logic [7:0] GS_POS_ERR       = 8'h01;
  localparam logic [7:0] GS_VELOCITY      = 8'h02;
  localparam logic [7:0] GS_TORQUE        = 8'h03;

  // Status and interrupt bit positions.
  localparam int unsigned BIT_MATCH       = 0;
  localparam int unsigned BIT_LOCK        = 1;
  localparam int unsigned BIT_GAIN2       = 2;
  localparam int unsigned NUM_EVT         = 3;

endpackage : servo_pkg

// *** core/servo_ms_delay.sv ***
/*
  Millisecond delay qualifier: output follows the request only after the
  request has stood for the programmed number of milliseconds.
  Assumes one clock and a synchronous request level.
*/
`timescale 1ns/1ps
module servo_ms_delay
  import servo_pkg::*;
#(
  parameter int unsigned MS_TICKS = MS_CYCLES
) (
  // Clock and reset.
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Request and delay.
  input  wire logic        i_req,
  input  wire logic [15:0] i_delay_ms,
  // Qualified level.
  output logic             o_done
);

  typedef struct packed {
    logic [31:0] tick;
    logic [15:0] ms;
    logic        done;
  } dly_state_t;

  dly_state_t st;
  dly_state_t next_st;

  // Count whole milliseconds while the request stands; clear when it drops.
  always_comb begin
    next_st = st;
    if (!i_req) begin
      next_st = '0;
    end else if (st.ms >= i_delay_ms) begin
      next_st.done = 1'b1;
    end else if (st.tick == 32'(MS_TICKS - 1)) begin
      next_st.tick = '0;
      next_st.ms   = st.ms + 16'h0001;
    end else begin
      next_st.tick = st.tick + 32'h0000_0001;
    end
  end

  // State register.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_done = st.done;

endmodule : servo_ms_delay

// *** test/motion_host.sv ***
/*
  Behavioural host motion controller: turns the bench's motion settings
  into registered feedback samples, one clock behind, like a sampled loop.
  Assumes one clock shared with the servo block.
*/
`timescale 1ns/1ps
module motion_host (
  // Clock and reset.
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Settings from the bench.
  input  wire logic [31:0] i_pos,
  input  wire logic [31:0] i_perr,
  input  wire logic [15:0] i_vcmd,
  input  wire logic [15:0] i_vact,
  input  wire logic [15:0] i_torq,
  // Feedback samples to the servo block.
  output logic [31:0]      o_pos,
  output logic [31:0]      o_perr,
  output logic [15:0]      o_vcmd,
  output logic [15:0]      o_vact,
  output logic [15:0]      o_torq
);
  // Samples move one clock after the settings, as a real sample path would.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      {o_pos, o_perr, o_vcmd, o_vact, o_torq} <= '0;
    end else begin
      {o_pos, o_perr, o_vcmd, o_vact, o_torq} <= {i_pos, i_perr, i_vcmd, i_vact, i_torq};
    end
  end
endmodule : motion_host

// *** test/tb.sv ***
/*
  Self-checking bench for the servo match and clamp block: register
  defaults, match window and polarity, interrupt, clamp lock, gain delay.
  Assumes MS_TICKS of 4 so that one millisecond lasts four clocks.
*/
`timescale 1ns/1ps
module tb;
  import servo_pkg::*;
  typedef struct {string name; logic [31:0] val;} note_t;
  logic i_mclk = 0, i_rst = 1, cyc = 0, stb = 0, we = 0, clamp_in = 1;
  logic probe = 0, probe_pos = 0, rd_pend = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] wdat = 0, pos = 0, perr = 0, lfsr = 32'ha097, a_pos, a_perr, rdat;
  logic [31:0] lock_pos;
  logic [15:0] vcmd = 16'h0100, vact = 0, torq = 0, a_vcmd, a_vact, a_torq;
  logic ack, match, gain2, vmode, lock, irq;
  int bad_count = 0, checks = 0;
  note_t notes[$];
  logic [7:0] ra[9] = '{OFS_TARGET, OFS_OUT_CODE, OFS_MODE, OFS_ZERO_THR, OFS_GS_METHOD,
                        OFS_GS_TORQ, OFS_DLY_2TO1, OFS_DLY_1TO2, 8'h40};
  logic [31:0] rv[9] = '{32'h2710, 32'h4, 32'h15, 32'h32, 32'h0, 32'ha, 32'ha, 32'h0, 32'h0};
  int offs[4] = '{100, -100, 101, -101};
  logic [7:0] codes[3] = '{8'h04, 8'h1f, 8'h20};

  always #4 i_mclk = ~i_mclk;

  motion_host host_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_pos(pos), .i_perr(perr),
    .i_vcmd(vcmd), .i_vact(vact), .i_torq(torq), .o_pos(a_pos), .o_perr(a_perr),
    .o_vcmd(a_vcmd), .o_vact(a_vact), .o_torq(a_torq));

  servo_match_clamp #(.MS_TICKS(4)) dut_u (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_actual_pos(a_pos),
    .i_pos_error(a_perr), .i_cmd_velocity(a_vcmd), .i_actual_velocity(a_vact),
    .i_actual_torque(a_torq), .i_clamp_request_input(clamp_in),
    .o_position_match_output(match), .o_gain_set2(gain2), .o_velocity_mode(vmode),
    .o_position_lock(lock), .o_lock_position(lock_pos), .o_irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  // Random noise on position error and torque, which no test here relies on.
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  always @(posedge i_mclk) begin
    lfsr <= lfsr_next(lfsr);
    perr <= lfsr;
    torq <= lfsr[31:16];
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // Watcher: each read answer or probe takes the oldest note and compares.
  always @(posedge i_mclk) begin
    note_t n;
    if ((ack === 1'b1 && rd_pend) || probe || probe_pos) begin
      if (notes.size() == 0) check("note queue", 32'h1, 32'h0);
      else begin
        n = notes.pop_front();
        check(n.name, rd_pend ? rdat : probe_pos ? lock_pos
                                     : {27'h0, gain2, vmode, lock, match, irq}, n.val);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One classic Wishbone cycle; request held until ack is seen at an edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] exp, input string name);
    int n;
    n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    rd_pend <= !w;
    if (!w) notes.push_back('{name, exp});
    do begin
      @(posedge i_mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      bad_count++;
      finish_test();
    end
    cyc <= 0;
    stb <= 0;
    rd_pend <= 0;
    @(posedge i_mclk);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 32'h0, "");
  endtask : wr

  // Notes the expected {gain2, vmode, lock, match, irq} after some cycles.
  task automatic look(input int wait_n, input logic [4:0] exp, input string name);
    repeat (wait_n) @(posedge i_mclk);
    notes.push_back('{name, {27'h0, exp}});
    probe <= 1;
    @(posedge i_mclk);
    probe <= 0;
  endtask : look

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    int off;
    logic in_win;
    repeat (12) @(posedge i_mclk);
    i_rst <= 0;
    @(posedge i_mclk);
    // Register defaults and an unmapped address.
    for (int i = 0; i < 9; i++) wb(1'b0, ra[i], 0, rv[i], "reset value");
    // Interrupt on a match rise at a random offset inside the window.
    wb(1'b0, OFS_IRQ_STAT, 0, 32'h0, "irq status idle");
    wr(OFS_IRQ_MASK, 32'h1);
    off = int'(lfsr % 201) - 100;
    pos <= 32'(10000 + off);
    look(5, 5'b00011, "match irq");
    wb(1'b0, OFS_IRQ_STAT, 0, 32'h1, "irq status");
    look(2, 5'b00010, "irq cleared");
    wr(OFS_IRQ_MASK, 32'h0);
    // Window edges under every output code.
    foreach (codes[c]) begin
      wr(OFS_OUT_CODE, {24'h0, codes[c]});
      foreach (offs[k]) begin
        pos <= 32'(10000 + offs[k]);
        in_win = (offs[k] <= 100 && offs[k] >= -100);
        look(5, {3'b000, (codes[c] == 8'h20) ? !in_win : in_win, 1'b0}, "match edge");
      end
    end
    wr(OFS_OUT_CODE, 32'h4);
    // Negative target.
    wr(OFS_TARGET, 32'hffff_ec78);
    pos <= 32'hffff_ec14;
    look(5, 5'b00010, "negative target");
    // Velocity mode and clamp at the threshold boundary.
    wr(OFS_MODE, 32'hf);
    pos <= 32'd12345;
    clamp_in <= 0;
    vcmd <= 16'd51;
    look(5, 5'b01000, "no lock above");
    vcmd <= 16'd50;
    look(5, 5'b01100, "lock at thr");
    // The lock position output itself, sampled by the watcher.
    notes.push_back('{"lock output", 32'd12345});
    probe_pos <= 1;
    @(posedge i_mclk);
    probe_pos <= 0;
    pos <= 32'd12400;
    wb(1'b0, OFS_LOCK_POS, 0, 32'd12345, "lock position");
    // Any method but 0 drops the lock; back to 0 locks again.
    wr(OFS_CLAMP_METH, 32'h1);
    look(5, 5'b01000, "lock off method 1");
    wr(OFS_CLAMP_METH, 32'h0);
    look(5, 5'b01100, "lock again");
    clamp_in <= 1;
    look(5, 5'b01000, "lock released");
    // Another input code makes the request active high.
    wr(OFS_CLAMP_IN_CODE, 32'h15);
    look(5, 5'b01100, "high input lock");
    wr(OFS_CLAMP_IN_CODE, 32'h1);
    // Gain switch on velocity, then the delayed return.
    wr(OFS_GS_VEL, 32'd100);
    wr(OFS_GS_METHOD, 32'h2);
    vact <= 16'd200;
    look(6, 5'b11000, "gain2 entry");
    vact <= 16'd0;
    look(20, 5'b11000, "gain2 held");
    look(40, 5'b01000, "gain1 back");
    // The host returns the drive to direct motion command mode.
    wr(OFS_MODE, 32'h15);
    look(3, 5'b00000, "mode 21");
    look(2, 5'b00000, "idle");
    finish_test();
  end
endmodule : tb
